// ==== design/rid_event_gen.sv ====
`timescale 1ns/1ns
module rid_event_gen #(
  parameter int CMP_W = rid_pkg::CMP_W_DEF,
  parameter int SMP_W = rid_pkg::SMP_W_DEF
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sampleStrobe,
  input wire logic [SMP_W-1:0] sampleIn,
  input wire logic bitStrobe,
  input wire logic frameStart,
  rid_evt_if.gen evt
);
  typedef struct packed {
    logic [SMP_W-1:0] sample;
    logic done;
    logic [CMP_W-1:0] count;
    logic matched;
    logic match;
  } rid_gen_type;

  rid_gen_type q;
  rid_gen_type d;
  logic [CMP_W-1:0] nextCount;

  always_comb begin
    d = q;
    nextCount = CMP_W'(q.count + 1'b1);
    // Sample stored at the same edge the done pulse rises
    d.done = sampleStrobe; // R09
    if (sampleStrobe) begin
      d.sample = sampleIn; // R09
    end
    d.match = 1'b0;
    if (frameStart) begin
      d.count = '0;
      d.matched = 1'b0;
    end else if (bitStrobe) begin
      d.count = nextCount;
      // One match per frame even if the counter wraps
      if (nextCount == evt.bitCompare && !q.matched) begin
        d.match = 1'b1; // R11
        d.matched = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign evt.sampleValue = q.sample;
  assign evt.sampleDone = q.done;
  assign evt.bitMatch = q.match;

  AST_SAMPLE_FIRST: assert property (@(posedge mclk) disable iff (sys_rst) // R09
    evt.sampleDone |-> $past(sampleStrobe) && (evt.sampleValue == $past(sampleIn)))
    else $error("sample done without fresh sample");

  AST_COUNT_MATCH: assert property (@(posedge mclk) disable iff (sys_rst) // R11
    evt.bitMatch |-> $past(bitStrobe) && (q.count == $past(evt.bitCompare)))
    else $error("bit match at wrong count");

  AST_MATCH_ONCE: assert property (@(posedge mclk) disable iff (sys_rst) // R11
    evt.bitMatch && !frameStart |=> !evt.bitMatch)
    else $error("bit match repeated");
endmodule

// ==== design/rid_top.sv ====
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
module rid_top #(
  parameter int CMP_W = rid_pkg::CMP_W_DEF,
  parameter int SMP_W = rid_pkg::SMP_W_DEF
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] radioEventIn,
  input wire logic sampleStrobe,
  input wire logic [SMP_W-1:0] sampleIn,
  input wire logic bitStrobe,
  output logic irq
);
  typedef struct packed {
    rid_pkg::rid_wr_type wr;
    logic awHave;
    logic wHave;
    logic [11:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [1:0] bResp;
    rid_pkg::rid_rd_type rd;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [31:0] enable;
    logic [31:0] status;
    logic [CMP_W-1:0] bcc;
  } rid_state_type;

  rid_state_type q;
  rid_state_type d;
  logic [31:0] strbMask;
  logic [31:0] wMask;
  logic [31:0] effMask;
  logic [31:0] evtVec;
  logic [31:0] statusClr;
  logic wrFire;
  rid_pkg::rid_reg_type wrReg;
  rid_pkg::rid_reg_type rdReg;

  rid_evt_if #(.CMP_W(CMP_W), .SMP_W(SMP_W)) evt ();

  rid_event_gen #(.CMP_W(CMP_W), .SMP_W(SMP_W)) u_gen (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .sampleStrobe(sampleStrobe),
    .sampleIn(sampleIn),
    .bitStrobe(bitStrobe),
    .frameStart(radioEventIn[rid_pkg::BIT_ADDRESS]),
    .evt(evt.gen)
  );

  assign evt.bitCompare = q.bcc;

  // Byte lanes of the write data
  for (genvar b = 0; b < 4; b++) begin : g_strb
    assign strbMask[8*b +: 8] = {8{q.wStrb[b]}};
  end

  assign wMask = q.wData & strbMask;
  // Only implemented event bits may change; others read zero
  assign effMask = wMask & rid_pkg::EVT_MASK;
  assign wrFire = (q.wr == rid_pkg::WR_WAIT) && q.awHave && q.wHave;
  assign wrReg = rid_pkg::rid_decode(q.awAddr);
  assign rdReg = rid_pkg::rid_decode(s_axi_araddr);

  // Direct radio events plus the two locally generated ones
  always_comb begin
    evtVec = radioEventIn & rid_pkg::DIRECT_MASK;
    evtVec[rid_pkg::BIT_SAMPLE_DONE] = evt.sampleDone; // R09
    evtVec[rid_pkg::BIT_COUNT_MATCH] = evt.bitMatch; // R11
  end

  assign s_axi_awready = (q.wr == rid_pkg::WR_WAIT) && !q.awHave;
  assign s_axi_wready = (q.wr == rid_pkg::WR_WAIT) && !q.wHave;
  assign s_axi_bvalid = (q.wr == rid_pkg::WR_RESP);
  assign s_axi_bresp = q.bResp;
  assign s_axi_arready = (q.rd == rid_pkg::RD_IDLE);
  assign s_axi_rvalid = (q.rd == rid_pkg::RD_DATA);
  assign s_axi_rdata = q.rData;
  assign s_axi_rresp = q.rResp;
  assign irq = |(q.status & q.enable); // R16

  always_comb begin
    d = q;
    statusClr = '0;

    // Address and data are taken independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.awHave = 1'b1;
      d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.wHave = 1'b1;
      d.wData = s_axi_wdata;
      d.wStrb = s_axi_wstrb;
    end

    case (q.wr)
      rid_pkg::WR_WAIT: begin
        if (wrFire) begin
          d.awHave = 1'b0;
          d.wHave = 1'b0;
          d.wr = rid_pkg::WR_RESP;
          d.bResp = rid_pkg::RESP_OKAY;
          case (wrReg)
            rid_pkg::REG_STATUS: begin
              statusClr = effMask;
            end
            rid_pkg::REG_ENSET: begin
              d.enable = q.enable | effMask; // R14
            end
            rid_pkg::REG_ENCLR: begin
              // Zero bits leave their enable alone
              d.enable = q.enable & ~effMask; // R01 R02 R03 R04 R05 R06 R07 R08 R10 R12 R13 R15
            end
            rid_pkg::REG_BCC: begin
              d.bcc = (q.bcc & ~wMask[CMP_W-1:0]) | (q.wData[CMP_W-1:0] & wMask[CMP_W-1:0]);
            end
            rid_pkg::REG_SAMPLE: begin
              d.bResp = rid_pkg::RESP_OKAY;
            end
            default: begin
              d.bResp = rid_pkg::RESP_SLVERR;
            end
          endcase
        end
      end
      rid_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          d.wr = rid_pkg::WR_WAIT;
        end
      end
      default: begin
        d.wr = rid_pkg::WR_WAIT;
      end
    endcase

    // A new event beats a clear landing in the same cycle
    d.status = (q.status & ~statusClr) | evtVec;

    case (q.rd)
      rid_pkg::RD_IDLE: begin
        if (s_axi_arvalid) begin
          d.rd = rid_pkg::RD_DATA;
          d.rResp = rid_pkg::RESP_OKAY;
          case (rdReg)
            rid_pkg::REG_STATUS: begin
              d.rData = q.status;
            end
            rid_pkg::REG_ENSET, rid_pkg::REG_ENCLR: begin
              d.rData = q.enable; // R14 R15
            end
            rid_pkg::REG_SAMPLE: begin
              d.rData = rid_pkg::DATA_W'(evt.sampleValue);
            end
            rid_pkg::REG_BCC: begin
              d.rData = rid_pkg::DATA_W'(q.bcc);
            end
            default: begin
              d.rData = '0;
              d.rResp = rid_pkg::RESP_SLVERR;
            end
          endcase
        end
      end
      rid_pkg::RD_DATA: begin
        if (s_axi_rready) begin
          d.rd = rid_pkg::RD_IDLE;
        end
      end
      default: begin
        d.rd = rid_pkg::RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.wr <= rid_pkg::WR_WAIT;
      q.rd <= rid_pkg::RD_IDLE;
      q.enable <= rid_pkg::ENABLE_RST; // R16
      q.status <= rid_pkg::STATUS_RST;
      q.bcc <= CMP_W'(rid_pkg::BCC_RST);
      q.rData <= rid_pkg::SAMPLE_RST;
    end else begin
      q <= d;
    end
  end

  sequence seqClrWrite;
    wrFire && (wrReg == rid_pkg::REG_ENCLR);
  endsequence

  sequence seqSetWrite;
    wrFire && (wrReg == rid_pkg::REG_ENSET);
  endsequence

  sequence seqEnableRead;
    s_axi_arready && s_axi_arvalid
      && ((rdReg == rid_pkg::REG_ENCLR) || (rdReg == rid_pkg::REG_ENSET));
  endsequence

  sequence seqRespWait;
    s_axi_bvalid && !s_axi_bready;
  endsequence

  AST_ENABLE_CLEARED: assert property (@(posedge mclk) disable iff (sys_rst) // R01 R02 R03 R04 R05 R06 R07 R08 R10 R12 R13
    seqClrWrite |=> ((q.enable & $past(effMask)) == '0) ##0 s_axi_bvalid)
    else $error("enable not cleared by disable write");

  AST_ZERO_KEEPS: assert property (@(posedge mclk) disable iff (sys_rst) // R15
    seqClrWrite |=> ((q.enable & ~$past(effMask)) == ($past(q.enable) & ~$past(effMask))))
    else $error("zero bit changed an enable");

  AST_ENABLE_SET: assert property (@(posedge mclk) disable iff (sys_rst) // R14
    seqSetWrite |=> ((q.enable & $past(effMask)) == $past(effMask)))
    else $error("enable not set by set write");

  AST_READ_ENABLE: assert property (@(posedge mclk) disable iff (sys_rst) // R15
    seqEnableRead |=> s_axi_rvalid && (s_axi_rdata == $past(q.enable))
      && (s_axi_rresp == rid_pkg::RESP_OKAY))
    else $error("read did not return enables");

  AST_RESET_ZERO: assert property (@(posedge mclk) disable iff (sys_rst) // R16
    $past(sys_rst) |-> (q.enable == '0) && !irq && (q.status == '0))
    else $error("state not zero after reset");

  AST_IRQ_EVENT: assert property (@(posedge mclk) disable iff (sys_rst) // R16
    (|(evtVec & q.enable)) && !(wrFire && (wrReg == rid_pkg::REG_ENCLR)) |=> irq)
    else $error("enabled event gave no interrupt");

  AST_STATUS_STICKY: assert property (@(posedge mclk) disable iff (sys_rst) // R16
    (|evtVec) |=> ((q.status & $past(evtVec)) == $past(evtVec)))
    else $error("event did not set status");

  AST_READ_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");

  AST_IRQ_QUIET: assert property (@(posedge mclk) disable iff (sys_rst) // R16
    ((q.enable & q.status) == '0) |-> !irq)
    else $error("interrupt without enabled event");

  AST_SET_WINS: assert property (@(posedge mclk) disable iff (sys_rst)
    (|(evtVec & statusClr)) |=> ((q.status & $past(evtVec & statusClr)) != '0))
    else $error("event lost under clear");

  AST_RESP_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    seqRespWait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

  AST_UNMAPPED: assert property (@(posedge mclk) disable iff (sys_rst)
    wrFire && (wrReg == rid_pkg::REG_NONE) |=> s_axi_bvalid
      && (s_axi_bresp == rid_pkg::RESP_SLVERR) && $stable(q.enable))
    else $error("unmapped write not refused");
endmodule

// ==== inc/rid_evt_if.sv ====
`timescale 1ns/1ns
interface rid_evt_if #(
  parameter int CMP_W = 16,
  parameter int SMP_W = 8
);
  logic [CMP_W-1:0] bitCompare;
  logic [SMP_W-1:0] sampleValue;
  logic sampleDone;
  logic bitMatch;

  modport gen (
    input bitCompare,
    output sampleValue,
    output sampleDone,
    output bitMatch
  );
  modport core (
    output bitCompare,
    input sampleValue,
    input sampleDone,
    input bitMatch
  );
endinterface

// ==== inc/rid_pkg.sv ====
// Overview of operation
// R01 - Writing one clears ready interrupt enable
// R02 - Writing one stops address event interrupt
// R03 - Writing one clears payload interrupt enable
// R04 - Writing one clears end interrupt enable
// R05 - Writing one clears disabled interrupt enable
// R06 - Writing one clears address match enable
// R07 - Writing one clears address miss enable
// R08 - Writing one clears sample done enable
// R09 - Sample done only after sample stored
// R10 - Writing one clears bit counter enable
// R11 - Bit counter match at compare value
// R12 - Writing one clears checksum pass enable
// R13 - Writing one clears checksum fail enable
// R14 - Enable-set register sets, reads shared enables
// R15 - Read shows enables; zero bits unchanged
// R16 - Reset zero; interrupt needs event and enable
package rid_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CMP_W_DEF = 16;
  localparam int SMP_W_DEF = 8;

  localparam logic [11:0] OFS_STATUS = 12'h100;
  localparam logic [11:0] OFS_ENSET = 12'h304;
  localparam logic [11:0] OFS_ENCLR = 12'h308;
  localparam logic [11:0] OFS_SAMPLE = 12'h548;
  localparam logic [11:0] OFS_BCC = 12'h560;

  localparam int BIT_READY = 0;
  localparam int BIT_ADDRESS = 1;
  localparam int BIT_PAYLOAD = 2;
  localparam int BIT_END = 3;
  localparam int BIT_DISABLED = 4;
  localparam int BIT_ADDR_MATCH = 5;
  localparam int BIT_ADDR_MISS = 6;
  localparam int BIT_SAMPLE_DONE = 7;
  localparam int BIT_COUNT_MATCH = 10;
  localparam int BIT_CHECK_PASS = 12;
  localparam int BIT_CHECK_FAIL = 13;

  localparam logic [31:0] ONE_BIT = 32'h0000_0001;
  localparam logic [31:0] GEN_MASK = (ONE_BIT << BIT_SAMPLE_DONE) | (ONE_BIT << BIT_COUNT_MATCH);
  localparam logic [31:0] DIRECT_MASK = (ONE_BIT << BIT_READY) | (ONE_BIT << BIT_ADDRESS)
    | (ONE_BIT << BIT_PAYLOAD) | (ONE_BIT << BIT_END) | (ONE_BIT << BIT_DISABLED)
    | (ONE_BIT << BIT_ADDR_MATCH) | (ONE_BIT << BIT_ADDR_MISS)
    | (ONE_BIT << BIT_CHECK_PASS) | (ONE_BIT << BIT_CHECK_FAIL);
  localparam logic [31:0] EVT_MASK = DIRECT_MASK | GEN_MASK;

  localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] BCC_RST = 32'h0000_0000;
  localparam logic [31:0] SAMPLE_RST = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {REG_NONE, REG_STATUS, REG_ENSET, REG_ENCLR, REG_SAMPLE, REG_BCC}
    rid_reg_type;
  typedef enum logic {WR_WAIT, WR_RESP} rid_wr_type;
  typedef enum logic {RD_IDLE, RD_DATA} rid_rd_type;

  function automatic rid_reg_type rid_decode(input logic [11:0] addr);
    rid_reg_type r;
    r = REG_NONE;
    // Low address bits ignored: word access only
    case ({addr[11:2], 2'h0})
      OFS_STATUS: r = REG_STATUS;
      OFS_ENSET: r = REG_ENSET;
      OFS_ENCLR: r = REG_ENCLR;
      OFS_SAMPLE: r = REG_SAMPLE;
      OFS_BCC: r = REG_BCC;
      default: r = REG_NONE;
    endcase
    return r;
  endfunction
endpackage

// ==== verif/rid_tb_top.sv ====
`timescale 1ns/1ns
module radio_interrupt_disable_reg_tb_top;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] awAddr = 12'h000;
  logic awValid = 1'b0;
  logic [31:0] wData = 32'h0000_0000;
  logic [3:0] wStrb = 4'hF;
  logic wValid = 1'b0;
  logic bReady = 1'b0;
  logic [11:0] arAddr = 12'h000;
  logic arValid = 1'b0;
  logic rReady = 1'b0;
  logic [31:0] evtIn = 32'h0000_0000;
  logic smpStb = 1'b0;
  logic [7:0] smpIn = 8'h00;
  logic bitStb = 1'b0;
  logic awReady;
  logic wReady;
  logic [1:0] bResp;
  logic bValid;
  logic arReady;
  logic [31:0] rData;
  logic [1:0] rResp;
  logic rValid;
  logic irq;
  int err_total = 0;
  int total_checks = 0;
  logic [31:0] expEn;
  logic [31:0] evBit;
  // Direct events first, generated ones last: only the first nine are pulsed directly
  int bits[11] = '{rid_pkg::BIT_READY, rid_pkg::BIT_ADDRESS, rid_pkg::BIT_PAYLOAD,
    rid_pkg::BIT_END, rid_pkg::BIT_DISABLED, rid_pkg::BIT_ADDR_MATCH, rid_pkg::BIT_ADDR_MISS,
    rid_pkg::BIT_CHECK_PASS, rid_pkg::BIT_CHECK_FAIL, rid_pkg::BIT_SAMPLE_DONE,
    rid_pkg::BIT_COUNT_MATCH};

  always #25 mclk = ~mclk;

  rid_top dut (
    .mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .radioEventIn(evtIn), .sampleStrobe(smpStb), .sampleIn(smpIn), .bitStrobe(bitStb),
    .irq(irq)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk1(input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic hang();
    err_total++;
    $display("[FAIL] t=%0t exp=%h got=%h bus wait ran out", $time, 1'b1, 1'b0);
    test_done();
  endtask

  // Bready held from the start: the slave may answer on any edge
  task automatic axiWrite(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    rs = 2'h3;
    @(posedge mclk);
    awAddr <= a;
    awValid <= 1'b1;
    wData <= v;
    wValid <= 1'b1;
    bReady <= 1'b1;
    repeat (50) begin
      @(posedge mclk);
      if (awValid && awReady === 1'b1) awValid <= 1'b0;
      if (wValid && wReady === 1'b1) wValid <= 1'b0;
      if (bValid === 1'b1) begin
        rs = bResp;
        bReady <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic axiRead(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    v = 32'h0000_0000;
    rs = 2'h3;
    @(posedge mclk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    repeat (50) begin
      @(posedge mclk);
      if (arValid && arReady === 1'b1) arValid <= 1'b0;
      if (rValid === 1'b1) begin
        v = rData;
        rs = rResp;
        rReady <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    logic [1:0] rs;
    axiWrite(a, v, rs);
    chk32({30'h0000_0000, er}, {30'h0000_0000, rs});
  endtask

  // Mask hides bits that other activity may set meanwhile
  task automatic rdCmp(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
    input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] rs;
    axiRead(a, v, rs);
    chk32(e, v & m);
    chk32({30'h0000_0000, er}, {30'h0000_0000, rs});
  endtask

  task automatic pulse(input logic [31:0] ev, input logic s, input logic b, input logic [7:0] v);
    @(posedge mclk);
    evtIn <= ev;
    smpStb <= s;
    bitStb <= b;
    smpIn <= v;
    @(posedge mclk);
    evtIn <= 32'h0000_0000;
    smpStb <= 1'b0;
    bitStb <= 1'b0;
  endtask

  task automatic irqCmp(input logic e, input int n);
    repeat (n) @(posedge mclk);
    #1;
    chk1(e, irq);
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rdCmp(rid_pkg::OFS_ENCLR, 32'hFFFF_FFFF, 32'h0000_0000, rid_pkg::RESP_OKAY);
    rdCmp(rid_pkg::OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000, rid_pkg::RESP_OKAY);
    irqCmp(1'b0, 1);
    $display("test reset done");
    wr(rid_pkg::OFS_ENSET, 32'hFFFF_FFFF, rid_pkg::RESP_OKAY);
    rdCmp(rid_pkg::OFS_ENCLR, 32'hFFFF_FFFF, rid_pkg::EVT_MASK, rid_pkg::RESP_OKAY);
    rdCmp(rid_pkg::OFS_ENSET, 32'hFFFF_FFFF, rid_pkg::EVT_MASK, rid_pkg::RESP_OKAY);
    wr(rid_pkg::OFS_ENCLR, 32'h0000_0000, rid_pkg::RESP_OKAY);
    rdCmp(rid_pkg::OFS_ENCLR, 32'hFFFF_FFFF, rid_pkg::EVT_MASK, rid_pkg::RESP_OKAY);
    expEn = rid_pkg::EVT_MASK;
    foreach (bits[i]) begin
      evBit = rid_pkg::ONE_BIT << bits[i];
      expEn = expEn & ~evBit;
      wr(rid_pkg::OFS_ENCLR, evBit, rid_pkg::RESP_OKAY);
      rdCmp(rid_pkg::OFS_ENCLR, 32'hFFFF_FFFF, expEn, rid_pkg::RESP_OKAY);
    end
    $display("test clear one by one done");
    for (int i = 0; i < 9; i++) begin
      evBit = rid_pkg::ONE_BIT << bits[i];
      wr(rid_pkg::OFS_STATUS, 32'hFFFF_FFFF, rid_pkg::RESP_OKAY);
      wr(rid_pkg::OFS_ENSET, evBit, rid_pkg::RESP_OKAY);
      pulse(evBit, 1'b0, 1'b0, 8'h00);
      irqCmp(1'b1, 2);
      wr(rid_pkg::OFS_ENCLR, evBit, rid_pkg::RESP_OKAY);
      irqCmp(1'b0, 2);
      rdCmp(rid_pkg::OFS_STATUS, rid_pkg::DIRECT_MASK, evBit, rid_pkg::RESP_OKAY);
    end
    $display("test event interrupt done");
    evBit = rid_pkg::ONE_BIT << rid_pkg::BIT_SAMPLE_DONE;
    wr(rid_pkg::OFS_STATUS, 32'hFFFF_FFFF, rid_pkg::RESP_OKAY);
    rdCmp(rid_pkg::OFS_STATUS, evBit, 32'h0000_0000, rid_pkg::RESP_OKAY);
    wr(rid_pkg::OFS_ENSET, evBit, rid_pkg::RESP_OKAY);
    pulse(32'h0000_0000, 1'b1, 1'b0, 8'hA5);
    irqCmp(1'b1, 3);
    rdCmp(rid_pkg::OFS_SAMPLE, 32'hFFFF_FFFF, 32'h0000_00A5, rid_pkg::RESP_OKAY);
    rdCmp(rid_pkg::OFS_STATUS, evBit, evBit, rid_pkg::RESP_OKAY);
    wr(rid_pkg::OFS_ENCLR, evBit, rid_pkg::RESP_OKAY);
    irqCmp(1'b0, 2);
    wr(rid_pkg::OFS_SAMPLE, 32'hFFFF_FFFF, rid_pkg::RESP_OKAY);
    rdCmp(rid_pkg::OFS_SAMPLE, 32'hFFFF_FFFF, 32'h0000_00A5, rid_pkg::RESP_OKAY);
    $display("test sample done");
    evBit = rid_pkg::ONE_BIT << rid_pkg::BIT_COUNT_MATCH;
    wr(rid_pkg::OFS_BCC, 32'h0000_0003, rid_pkg::RESP_OKAY);
    rdCmp(rid_pkg::OFS_BCC, 32'hFFFF_FFFF, 32'h0000_0003, rid_pkg::RESP_OKAY);
    pulse(rid_pkg::ONE_BIT << rid_pkg::BIT_ADDRESS, 1'b0, 1'b0, 8'h00);
    wr(rid_pkg::OFS_STATUS, evBit, rid_pkg::RESP_OKAY);
    repeat (2) pulse(32'h0000_0000, 1'b0, 1'b1, 8'h00);
    rdCmp(rid_pkg::OFS_STATUS, evBit, 32'h0000_0000, rid_pkg::RESP_OKAY);
    pulse(32'h0000_0000, 1'b0, 1'b1, 8'h00);
    rdCmp(rid_pkg::OFS_STATUS, evBit, evBit, rid_pkg::RESP_OKAY);
    $display("test bit counter done");
    wr(rid_pkg::OFS_ENSET, 32'hFFFF_FFFF, rid_pkg::RESP_OKAY);
    @(posedge mclk);
    wStrb <= 4'h2;
    wr(rid_pkg::OFS_ENCLR, 32'hFFFF_FFFF, rid_pkg::RESP_OKAY);
    @(posedge mclk);
    wStrb <= 4'hF;
    rdCmp(rid_pkg::OFS_ENCLR, 32'hFFFF_FFFF, rid_pkg::EVT_MASK & 32'hFFFF_00FF,
      rid_pkg::RESP_OKAY);
    irqCmp(1'b1, 1);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rdCmp(rid_pkg::OFS_ENCLR, 32'hFFFF_FFFF, 32'h0000_0000, rid_pkg::RESP_OKAY);
    rdCmp(rid_pkg::OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000, rid_pkg::RESP_OKAY);
    irqCmp(1'b0, 1);
    $display("test strobe and second reset done");
    rdCmp(12'h000, 32'hFFFF_FFFF, 32'h0000_0000, rid_pkg::RESP_SLVERR);
    wr(12'h004, 32'hFFFF_FFFF, rid_pkg::RESP_SLVERR);
    $display("test unmapped done");
    test_done();
  end
endmodule
